// ---- cps_pkg.sv ----
package cps_pkg;
	// Clock and converter timing
	localparam int CLK_NS = 8;
	localparam int CONV_NS = 2000;
	localparam int TEMP_BUF_NS = 5000;
	localparam int TEMP_UNBUF_NS = 20000;
	localparam int TRACK_NS = 500;
	localparam logic [11:0] CONV_CYC = 12'((CONV_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [11:0] TEMP_BUF_CYC = 12'((TEMP_BUF_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [11:0] TEMP_UNBUF_CYC = 12'((TEMP_UNBUF_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [11:0] TRACK_CYC = 12'((TRACK_NS + CLK_NS - 1) / CLK_NS);
	// Serial frame
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam int F_CMD = 15;
	// Control register addresses
	localparam logic [3:0] A_DAC_RB = 4'h1;
	localparam logic [3:0] A_SEQ = 4'h2;
	localparam logic [3:0] A_GPCTRL = 4'h3;
	localparam logic [3:0] A_ADC_CFG = 4'h4;
	localparam logic [3:0] A_DAC_CFG = 4'h5;
	localparam logic [3:0] A_PULLDN = 4'h6;
	localparam logic [3:0] A_LOAD_MODE = 4'h7;
	localparam logic [3:0] A_GPIO_WCFG = 4'h8;
	localparam logic [3:0] A_GPIO_WDATA = 4'h9;
	localparam logic [3:0] A_GPIO_RCFG = 4'hA;
	localparam logic [3:0] A_PWRDN = 4'hB;
	localparam logic [3:0] A_OPEN_DRAIN = 4'hC;
	localparam logic [3:0] A_TRISTATE = 4'hD;
	localparam logic [3:0] A_SWRST = 4'hF;
	// Field positions
	localparam int F_TEMP = 8;
	localparam int F_DAC_GAIN = 4;
	localparam int F_ADC_RANGE = 5;
	localparam int F_BUSY_PIN = 8;
	localparam int F_GPIO_RB = 10;
	localparam int F_REF_EN = 9;
	localparam int F_DRB_EN = 3;
	localparam int HIGHEST_PIN = 7;
	localparam logic [3:0] TEMP_SLOT = 4'h8;
	localparam logic [3:0] TEMP_ADDR = 4'h8;
	localparam logic [10:0] SWRST_KEY = 11'h5AC;
	// Reset values
	localparam logic [7:0] PULLDN_RST = 8'hFF;
	localparam logic BUF_EN_RST = 1'b1;
	// Bus offsets
	localparam logic [7:0] AP_CTRL = 8'h00;
	localparam logic [7:0] AP_STATUS = 8'h04;
	localparam logic [7:0] AP_DSEL = 8'h08;
	localparam logic [7:0] AP_DVAL = 8'h0C;
	localparam logic [7:0] AP_LAST = 8'h10;
	// DAC load behaviour
	typedef enum logic [1:0] {LOAD_DIRECT, LOAD_DEFERRED, LOAD_TRANSFER, LOAD_RSVD} cps_load_t;
endpackage : cps_pkg

// ---- cps_core_if.sv ----
`timescale 1ns/1ps
interface cps_core_if;
	logic frame_start;
	logic frame_end;
	logic [15:0] rx_word;
	logic [15:0] tx_word;
	logic conv_start;
	logic conv_clr;
	logic [11:0] conv_len;
	logic conv_done;
	logic conv_busy;
	modport link(output frame_start, frame_end, rx_word, input tx_word);
	modport timer(input conv_start, conv_clr, conv_len, output conv_done, conv_busy);
	modport core(input frame_start, frame_end, rx_word, conv_done, conv_busy,
		output tx_word, conv_start, conv_clr, conv_len);
endinterface : cps_core_if

// ---- cps_conv_timer.sv ----
`timescale 1ns/1ps
module cps_conv_timer (
	input wire logic pclk,
	input wire logic presetn,
	cps_core_if.timer cv
);
	typedef struct packed {
		logic busy;
		logic done;
		logic [11:0] cnt;
	} cps_tmr_st_t;
	cps_tmr_st_t q;
	cps_tmr_st_t d;

	// Count down the conversion time, pulse done at the end
	always_comb
	begin
		d = q;
		d.done = 1'b0;
		if (cv.conv_clr)
		begin
			d.busy = 1'b0;
			d.cnt = 12'h000;
		end
		else if (q.busy)
		begin
			if (q.cnt == 12'h001)
			begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end
			else
				d.cnt = q.cnt - 12'h001;
		end
		else if (cv.conv_start)
		begin
			d.busy = 1'b1;
			d.cnt = cv.conv_len;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= '0;
		else
			q <= d;
	end

	assign cv.conv_done = q.done;
	assign cv.conv_busy = q.busy;
endmodule : cps_conv_timer

// ---- cps_spi_link.sv ----
`timescale 1ns/1ps
module cps_spi_link (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sync_n,
	input wire logic sclk,
	input wire logic sdi,
	output logic sdo,
	cps_core_if.link lk
);
	// Bit 2 frame select, bit 1 serial clock, bit 0 data in
	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic [1:0] s3;
		logic [15:0] rx;
		logic [15:0] tx;
		logic [4:0] cnt;
		logic sdo;
		logic start;
		logic fin;
	} cps_spi_st_t;
	cps_spi_st_t q;
	cps_spi_st_t d;

	// Pins are oversampled; edges are found on the second stage only
	always_comb
	begin
		d = q;
		d.start = 1'b0;
		d.fin = 1'b0;
		d.s1 = {sync_n, sclk, sdi};
		d.s2 = q.s1;
		d.s3 = q.s2[2:1];
		if (q.s3[1] && !q.s2[2])
		begin
			d.start = 1'b1;
			d.cnt = 5'h00;
			d.tx = lk.tx_word;
			d.sdo = lk.tx_word[15];
		end
		else if (!q.s3[1] && q.s2[2])
		begin
			// Only a complete frame is executed
			d.fin = (q.cnt == cps_pkg::FRAME_BITS);
			d.sdo = 1'b0;
		end
		else if (!q.s2[2])
		begin
			if (q.s3[0] && !q.s2[1])
			begin
				d.rx = {q.rx[14:0], q.s2[0]};
				if (q.cnt != 5'h1F)
					d.cnt = q.cnt + 5'h01;
			end
			else if (!q.s3[0] && q.s2[1])
			begin
				d.tx = {q.tx[14:0], 1'b0};
				d.sdo = q.tx[14];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= '0;
		else
			q <= d;
	end

	assign sdo = q.sdo;
	assign lk.frame_start = q.start;
	assign lk.frame_end = q.fin;
	assign lk.rx_word = q.rx;
endmodule : cps_spi_link

// ---- cps_top.sv ----
// Contract
// - each pin is DAC, ADC, GPIO in or out
// - one gain bit sets every DAC range
// - DAC codes are straight binary, 0 to 4095
// - DAC updates at once unless deferred load
// - sequencer advances mux to next selected channel
// - first channel tracks after sequence write; 500 ns
// - first frame-select fall converts first channel
// - later falls convert next, shift previous result
// - result frame: 0, 3-bit address, 12-bit data
// - highest pin as busy: low while converting; here high for one cycle after the launch pulse
// - bit 5 sets ADC range; binary output
// - pin both DAC and ADC stays DAC, converts
// - GPIO configs set direction; data drives outputs
// - readback bit 10 sends pin states next frame
// - pins both in and out are read back
// - reference off after reset; bit 9 enables
// - reset pin restores defaults and pull-downs
// - writing 0x5AC to reset register resets all; here buf_en and dsel keep their values
// - sequence bit 8 appends temperature, address 0b1000
// - temperature takes 5 us buffered, 20 unbuffered
// - 16 bits on clock falls, execute at rise
// - bit 15 selects control or DAC write
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
module cps_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sync_n,
	input wire logic sclk,
	input wire logic sdi,
	output logic sdo,
	input wire logic [7:0] configurable_pin_in,
	output logic [7:0] configurable_pin_out,
	output logic [7:0] configurable_pin_oe_n,
	output logic [7:0] pin_pulldown,
	output logic [7:0] pin_dac_en,
	output logic [7:0] pin_adc_en,
	output logic [95:0] dac_value,
	output logic dac_gain,
	output logic adc_range,
	output logic ref_en,
	output logic [3:0] adc_mux,
	output logic adc_start,
	input wire logic [11:0] adc_data
);
	typedef struct packed {
		logic [8:0] seq;
		logic [7:0] gpctrl;
		logic [7:0] adc_cfg;
		logic [7:0] dac_cfg;
		logic [7:0] pulldn;
		cps_pkg::cps_load_t load_mode;
		logic [8:0] gwcfg;
		logic [7:0] gwdata;
		logic [10:0] grcfg;
		logic [7:0] dac_pd;
		logic [7:0] dac_en;
		logic ref_en;
		logic [7:0] od;
		logic [7:0] tri_st;
		logic [7:0][11:0] dac_in;
		logic [7:0][11:0] dac_out;
		logic [3:0] pos;
		logic [3:0] conv_ch;
		logic res_valid;
		logic [15:0] res;
		logic [15:0] last;
		logic gpio_pend;
		logic drb_pend;
		logic [2:0] drb_ch;
		logic [7:0] io_s1;
		logic [7:0] io_s2;
		logic [7:0] io_out;
		logic [7:0] io_oe_n;
		logic start;
		logic clr;
		logic [11:0] len;
		logic [3:0] mux;
		logic buf_en;
		logic [2:0] dsel;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} cps_top_st_t;

	function automatic cps_top_st_t rst_val();
		cps_top_st_t r;
		r = '0;
		r.pulldn = cps_pkg::PULLDN_RST;
		r.buf_en = cps_pkg::BUF_EN_RST;
		r.io_oe_n = 8'hFF;
		return r;
	endfunction : rst_val

	localparam cps_top_st_t RST_ST = rst_val();

	// Next selected slot after cur, wrapping; slot 8 is temperature
	function automatic logic [3:0] nxt_slot(input logic [8:0] m, input logic [3:0] cur);
		logic [3:0] r;
		int idx;
		r = cur;
		for (int i = 9; i >= 1; i--)
		begin
			idx = (int'(cur) + i) % 9;
			if (m[idx])
				r = 4'(idx);
		end
		return r;
	endfunction : nxt_slot

	// Bus decode, shared by read and write paths
	function automatic logic apb_hit(input logic [7:0] a);
		return (a == cps_pkg::AP_CTRL) || (a == cps_pkg::AP_STATUS) ||
			(a == cps_pkg::AP_DSEL) || (a == cps_pkg::AP_DVAL) || (a == cps_pkg::AP_LAST);
	endfunction : apb_hit

	cps_top_st_t q;
	cps_top_st_t d;
	logic [15:0] w;
	logic [3:0] n;
	logic drv;
	logic val;
	logic busy;

	cps_core_if cf();

	cps_spi_link u_link (
		.pclk(pclk),
		.presetn(presetn),
		.sync_n(sync_n),
		.sclk(sclk),
		.sdi(sdi),
		.sdo(sdo),
		.lk(cf.link)
	);

	cps_conv_timer u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.cv(cf.timer)
	);

	// Word offered to the next frame: pin states, DAC readback, then ADC result
	assign cf.tx_word = q.gpio_pend ? {8'h00, q.io_s2 & q.grcfg[7:0]} :
		q.drb_pend ? {1'b1, q.drb_ch, q.dac_in[q.drb_ch]} :
		q.res_valid ? q.res : 16'h0000;
	assign cf.conv_start = q.start;
	assign cf.conv_clr = q.clr;
	assign cf.conv_len = q.len;

	always_comb
	begin
		d = q;
		w = cf.rx_word;
		n = 4'h0;
		drv = 1'b0;
		val = 1'b0;
		busy = 1'b0;
		d.start = 1'b0;
		d.clr = 1'b0;
		d.io_s1 = configurable_pin_in;
		d.io_s2 = q.io_s1;

		// Result capture; the tag tells temperature from channels
		if (cf.conv_done)
		begin
			if (q.conv_ch == cps_pkg::TEMP_SLOT)
				d.res = {cps_pkg::TEMP_ADDR, adc_data};
			else
				d.res = {1'b0, q.conv_ch[2:0], adc_data};
			d.last = d.res;
			d.res_valid = 1'b1;
			// Next channel goes back to tracking
			d.mux = q.pos;
		end

		// Frame start: hand out pending word and launch conversion
		if (cf.frame_start)
		begin
			if (q.gpio_pend)
				d.gpio_pend = 1'b0;
			else if (q.drb_pend)
				d.drb_pend = 1'b0;
			else
				d.res_valid = cf.conv_done;
			// A start during a conversion is the host's fault and is dropped
			if ((q.seq != 9'h000) && !cf.conv_busy)
			begin
				d.start = 1'b1;
				d.conv_ch = q.pos;
				d.mux = q.pos;
				if (q.pos == cps_pkg::TEMP_SLOT)
					d.len = q.buf_en ? cps_pkg::TEMP_BUF_CYC : cps_pkg::TEMP_UNBUF_CYC;
				else
					d.len = cps_pkg::CONV_CYC;
				d.pos = nxt_slot(q.seq, q.pos);
			end
		end

		// Commands execute when the frame closes
		if (cf.frame_end)
		begin
			if (w[cps_pkg::F_CMD])
			begin
				// Codes pass untouched: straight binary
				d.dac_in[w[14:12]] = w[11:0];
				if (q.load_mode != cps_pkg::LOAD_DEFERRED)
					d.dac_out[w[14:12]] = w[11:0];
			end
			else
			begin
				case (w[14:11])
					cps_pkg::A_DAC_RB:
					begin
						d.drb_pend = w[cps_pkg::F_DRB_EN + 1] & w[cps_pkg::F_DRB_EN];
						d.drb_ch = w[2:0];
					end
					cps_pkg::A_SEQ:
					begin
						d.seq = w[8:0];
						n = nxt_slot(w[8:0], cps_pkg::TEMP_SLOT);
						d.pos = n;
						// First channel tracks from here on
						d.mux = n;
						d.res_valid = 1'b0;
					end
					cps_pkg::A_GPCTRL:
						d.gpctrl = w[7:0];
					cps_pkg::A_ADC_CFG:
						d.adc_cfg = w[7:0];
					cps_pkg::A_DAC_CFG:
						d.dac_cfg = w[7:0];
					cps_pkg::A_PULLDN:
						d.pulldn = w[7:0];
					cps_pkg::A_LOAD_MODE:
					begin
						// Transfer copies every input register once, mode is kept
						if (w[1:0] == 2'(cps_pkg::LOAD_TRANSFER))
							d.dac_out = q.dac_in;
						else
							d.load_mode = cps_pkg::cps_load_t'(w[1:0]);
					end
					cps_pkg::A_GPIO_WCFG:
						d.gwcfg = w[8:0];
					cps_pkg::A_GPIO_WDATA:
						d.gwdata = w[7:0];
					cps_pkg::A_GPIO_RCFG:
					begin
						d.grcfg = w[10:0];
						d.gpio_pend = w[cps_pkg::F_GPIO_RB];
					end
					cps_pkg::A_PWRDN:
					begin
						d.dac_pd = w[7:0];
						d.ref_en = w[cps_pkg::F_REF_EN];
					end
					cps_pkg::A_OPEN_DRAIN:
						d.od = w[7:0];
					cps_pkg::A_TRISTATE:
						d.tri_st = w[7:0];
					cps_pkg::A_SWRST:
					begin
						if (w[10:0] == cps_pkg::SWRST_KEY)
						begin
							d = RST_ST;
							d.io_s1 = configurable_pin_in;
							d.io_s2 = q.io_s1;
							d.buf_en = q.buf_en;
							d.dsel = q.dsel;
							// Abort a conversion still running
							d.clr = 1'b1;
						end
					end
					default:
					begin
					end
				endcase
			end
		end

		// Busy goes low with the launch pulse, back high for the next cycle, then low until the result lands
		busy = d.start | cf.conv_busy;
		for (int i = 0; i < 8; i++)
		begin
			// A DAC pin is not driven digitally, even if also ADC, unless it is pin 7 used as busy
			drv = d.gwcfg[i] && !d.dac_cfg[i] && !d.tri_st[i];
			val = d.gwdata[i];
			if ((i == cps_pkg::HIGHEST_PIN) && d.gwcfg[cps_pkg::F_BUSY_PIN])
			begin
				drv = 1'b1;
				val = !busy;
			end
			// Open drain only pulls low
			if (d.od[i] && val)
				drv = 1'b0;
			d.io_oe_n[i] = !drv;
			d.io_out[i] = val;
		end
		d.dac_en = d.dac_cfg & ~d.dac_pd;
		// Bus slave: one wait state, response registered
		d.pready = psel && penable && !q.pready;
		d.pslverr = 1'b0;
		d.prdata = 32'h0000_0000;
		if (psel && penable && !q.pready)
		begin
			d.pslverr = !apb_hit(paddr);
			case (paddr)
				cps_pkg::AP_CTRL:
					d.prdata = {31'h0000_0000, q.buf_en};
				cps_pkg::AP_STATUS:
					d.prdata = {19'h0_0000, q.pos, q.conv_ch, q.gpctrl[cps_pkg::F_ADC_RANGE],
						q.gpctrl[cps_pkg::F_DAC_GAIN], q.ref_en, q.res_valid, cf.conv_busy};
				cps_pkg::AP_DSEL:
					d.prdata = {29'h0000_0000, q.dsel};
				cps_pkg::AP_DVAL:
					d.prdata = {20'h0_0000, q.dac_out[q.dsel]};
				cps_pkg::AP_LAST:
					d.prdata = {16'h0000, q.last};
				default:
					d.prdata = 32'h0000_0000;
			endcase
		end
		// Writes land on the edge that completes the access
		if (psel && penable && q.pready && pwrite && apb_hit(paddr))
		begin
			if (paddr == cps_pkg::AP_CTRL)
				d.buf_en = pwdata[0];
			if (paddr == cps_pkg::AP_DSEL)
				d.dsel = pwdata[2:0];
		end
	end

	// Reset pin returns every register and pin to default
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= RST_ST;
		else
			q <= d;
	end

	// Outputs straight from the state register
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign configurable_pin_out = q.io_out;
	assign configurable_pin_oe_n = q.io_oe_n;
	assign pin_pulldown = q.pulldn;
	assign pin_dac_en = q.dac_en;
	assign pin_adc_en = q.adc_cfg;
	assign dac_value = q.dac_out;
	assign dac_gain = q.gpctrl[cps_pkg::F_DAC_GAIN];
	assign adc_range = q.gpctrl[cps_pkg::F_ADC_RANGE];
	assign ref_en = q.ref_en;
	assign adc_mux = q.mux;
	assign adc_start = q.start;
endmodule : cps_top

// ---- cps_checker.sv ----
`timescale 1ns/1ps
module cps_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	input wire logic sync_n,
	input wire logic sdo,
	input wire logic adc_start,
	input wire logic [3:0] adc_mux,
	input wire logic [95:0] dac_value
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Bus answers one edge into the access phase, for one cycle only
	a_ready_next: assert property ($rose(psel && penable) |=> pready)
		else $error("no pready after access");
	a_ready_access: assert property (pready |-> psel && penable ##1 !pready)
		else $error("pready outside access or too long");
	// Refusal carries no data
	a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("pslverr without pready or with data");
	// Conversion launch is a single pulse inside a frame
	a_start_pulse: assert property (adc_start |=> !adc_start)
		else $error("adc_start longer than one cycle");
	a_start_frame: assert property (adc_start |-> !sync_n && !$past(sync_n, 3))
		else $error("adc_start outside a frame");
	// Output line rests low between frames, after synchroniser delay
	a_sdo_idle: assert property (sync_n [*5] |-> !sdo)
		else $error("sdo not low between frames");
	// Mux only ever selects a pin or the temperature slot
	a_mux_slot: assert property (adc_mux <= 4'h8)
		else $error("adc_mux beyond temperature slot");
	// Direct load lands only once the frame has closed
	a_dac_at_end: assert property ($changed(dac_value) |-> sync_n && $past(sync_n, 2))
		else $error("dac_value changed inside a frame");
endmodule : cps_checker
bind cps_top cps_checker cps_checker_i (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
	.prdata, .sync_n, .sdo, .adc_start, .adc_mux, .dac_value);

// ---- cps_spi_host.sv ----
`timescale 1ns/1ps
module cps_spi_host (
	input wire logic pclk,
	input wire logic sdo,
	output logic sync_n,
	output logic sclk,
	output logic sdi
);
	logic act = 1'b0;
	initial
	begin
		sync_n = 1'b1;
		sclk = 1'b1;
		sdi = 1'b0;
	end
	// Released data line never keeps its last bit
	always @(posedge pclk)
		if (!act)
			sdi <= ~sdi;
	// One whole frame, MSB first; clock idles high, 64 ns period
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		int i;
		@(posedge pclk);
		act <= 1'b1;
		sync_n <= 1'b0;
		repeat (4) @(posedge pclk);
		for (i = 15; i >= 0; i--)
		begin
			sdi <= tx[i];
			repeat (4) @(posedge pclk);
			rx[i] = sdo;
			sclk <= 1'b0;
			repeat (4) @(posedge pclk);
			sclk <= 1'b1;
		end
		repeat (4) @(posedge pclk);
		sync_n <= 1'b1;
		act <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask : xfer
endmodule : cps_spi_host

// ---- cps_top_test.sv ----
`timescale 1ns/1ps
module cps_top_test;
	localparam int RST_WAIT = 31250; // 250 us of 8 ns cycles
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [7:0] pin_in = 8'h00;
	logic [7:0] pin_ext = 8'h00;
	logic [11:0] adc_data = 12'h000;
	logic [11:0] ana [0:15];
	logic [3:0] sl [0:2] = '{4'h1, 4'h2, 4'h8};
	logic [31:0] prdata;
	logic pready, pslverr, sync_n, sclk, sdi, sdo, dac_gain, adc_range, ref_en, adc_start;
	logic [7:0] pin_out, oe_n, pin_pulldown, pin_dac_en, pin_adc_en;
	logic [95:0] dac_value;
	logic [3:0] adc_mux;
	logic [31:0] lfsr = 32'h8D69CE15;
	int n_fail = 0;
	int check_count = 0;
	int n_start = 0;
	always #4 pclk = ~pclk;
	cps_top cps_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .sync_n, .sclk, .sdi, .sdo, .configurable_pin_in(pin_in),
		.configurable_pin_out(pin_out), .configurable_pin_oe_n(oe_n), .pin_pulldown,
		.pin_dac_en, .pin_adc_en, .dac_value, .dac_gain, .adc_range, .ref_en, .adc_mux,
		.adc_start, .adc_data);
	cps_spi_host cps_spi_host_i (.pclk, .sdo, .sync_n, .sclk, .sdi);
	// Pin wire: design drive where enabled, else the outside level
	always @(posedge pclk)
	begin
		pin_in <= (~oe_n & pin_out) | (oe_n & pin_ext);
		adc_data <= ana[adc_mux];
		if (adc_start === 1'b1)
			n_start <= n_start + 1;
	end
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : rnd
	// Result word as it should leave the device
	function automatic logic [15:0] res(input logic [3:0] s, input logic [11:0] v);
		return (s == 4'h8) ? {4'h8, v} : {1'b0, s[2:0], v};
	endfunction : res
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			n_fail++;
		end
	endtask : check
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test
	// Bus cycle held until pready; a lost answer ends the run
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 50; k++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (k == 50)
		begin
			n_fail++;
			end_of_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [3:0] a, input logic [10:0] d);
		logic [15:0] rx;
		cps_spi_host_i.xfer({1'b0, a, d}, rx);
	endtask : wr
	task automatic dflt();
		check("pulldown", 32'hFF, 32'(pin_pulldown));
		check("oe_n", 32'hFF, 32'(oe_n));
		check("ref_off", 32'h0, 32'(ref_en));
		check("dac_zero", 32'h0, {24'h0, pin_dac_en} | {31'h0, |dac_value});
	endtask : dflt
	initial
	begin
		repeat (95000) @(posedge pclk);
		n_fail++;
		end_of_test();
	end
	initial
	begin
		logic [15:0] rx;
		logic [31:0] rd;
		logic err;
		logic [11:0] code [0:3];
		logic [7:0] gp;
		int i;
		int n0;
		for (i = 0; i < 16; i++)
			ana[i] = 12'(rnd());
		ana[1] = 12'hFFF;
		pin_ext <= 8'(rnd());
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		dflt();
		apb(1'b0, cps_pkg::AP_CTRL, 32'h0, rd, err);
		check("ctrl", 32'h1, rd);
		apb(1'b1, 8'h14, 32'hFFFF_FFFF, rd, err);
		check("unmapped", 32'h1, {31'h0, err});
		check("unmapped_data", 32'h0, rd);
		repeat (RST_WAIT) @(posedge pclk);
		wr(cps_pkg::A_DAC_CFG, 11'h00F);
		wr(cps_pkg::A_GPCTRL, 11'h030);
		wr(cps_pkg::A_PWRDN, 11'h200);
		check("dac_en", 32'h0F, 32'(pin_dac_en));
		check("gain_range", 32'h3, {30'h0, dac_gain, adc_range});
		check("ref_on", 32'h1, 32'(ref_en));
		for (i = 0; i < 4; i++)
		begin
			code[i] = (i == 0) ? 12'hFFF : 12'(rnd());
			cps_spi_host_i.xfer({1'b1, 3'(i), code[i]}, rx);
			check("dac_code", 32'(code[i]), 32'(dac_value[i*12 +: 12]));
		end
		apb(1'b1, cps_pkg::AP_DSEL, 32'h2, rd, err);
		apb(1'b0, cps_pkg::AP_DVAL, 32'h0, rd, err);
		check("dval", 32'(code[2]), rd);
		// Deferred load holds the output until the transfer command
		wr(cps_pkg::A_LOAD_MODE, 11'h001);
		cps_spi_host_i.xfer({4'h8, 12'h5A3}, rx);
		check("dac_held", 32'hFFF, 32'(dac_value[11:0]));
		wr(cps_pkg::A_LOAD_MODE, 11'h002);
		check("dac_loaded", 32'h5A3, 32'(dac_value[11:0]));
		wr(cps_pkg::A_DAC_RB, 11'h01A);
		cps_spi_host_i.xfer(16'h0000, rx);
		check("dac_rb", 32'({4'hA, code[2]}), 32'(rx));
		gp = 8'(rnd());
		wr(cps_pkg::A_GPIO_WCFG, 11'h130);
		wr(cps_pkg::A_GPIO_WDATA, {3'h0, gp});
		check("gpio", {28'h0, gp[5:4], 2'b00}, {28'h0, pin_out[5:4], oe_n[5:4]});
		wr(cps_pkg::A_GPIO_RCFG, 11'h470);
		cps_spi_host_i.xfer(16'h0000, rx);
		check("gpio_rb", {24'h0, {pin_ext[7:6], gp[5:4], 4'h0} & 8'h70}, 32'(rx));
		wr(cps_pkg::A_GPIO_RCFG, 11'h070);
		wr(cps_pkg::A_ADC_CFG, 11'h006);
		check("adc_en", 32'h06, 32'(pin_adc_en));
		wr(cps_pkg::A_SEQ, 11'h106);
		repeat (70) @(posedge pclk);
		check("track_mux", 32'h1, 32'(adc_mux));
		for (i = 0; i < 4; i++)
		begin
			n0 = n_start;
			cps_spi_host_i.xfer(16'h0000, rx);
			if (i > 0)
				check("adc_word", 32'(res(sl[i-1], ana[sl[i-1]])), 32'(rx));
			check("started", 32'(n0 + 1), 32'(n_start));
			check("busy_low", 32'h0, 32'(pin_out[7]));
			repeat (700) @(posedge pclk);
			check("busy_high", 32'h1, 32'(pin_out[7]));
		end
		apb(1'b0, cps_pkg::AP_LAST, 32'h0, rd, err);
		check("last", 32'(res(4'h1, ana[1])), rd);
		wr(cps_pkg::A_SEQ, 11'h000);
		repeat (700) @(posedge pclk);
		n0 = n_start;
		cps_spi_host_i.xfer(16'h0000, rx);
		check("no_start", 32'(n0), 32'(n_start));
		wr(cps_pkg::A_SWRST, 11'h5AB);
		check("ref_kept", 32'h1, 32'(ref_en));
		wr(cps_pkg::A_SWRST, 11'h5AC);
		dflt();
		repeat (RST_WAIT) @(posedge pclk);
		wr(cps_pkg::A_PWRDN, 11'h200);
		check("ref_again", 32'h1, 32'(ref_en));
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		dflt();
		end_of_test();
	end
endmodule : cps_top_test
